// ===== rtl/stm_top.sv
// Contract
// - read own die and three remote junctions, four readable channels
// - each result is sign plus seven bits, one degree per lsb
// - interrupt output asserts while any channel exceeds its high limit
// - critical alarm asserts while any channel exceeds the shared critical limit
// - critical and four high limits are host writable and read back
// - all limits reset to 127 degrees
// - two tri-level strap pins select one of nine slave addresses
// - temperature and limit registers reachable through an smbus compatible slave
// - stalled transaction times out and the slave releases the bus
// - data line is open drain here, pulled up by the controller
// - serial clock is input only, driven and pulled up outside
// - interrupt output is open drain, pulled up by the receiver
// - critical alarm is open drain, pulled up outside
// - one pass over four channels about 460 ms, at most 600 ms
`timescale 1ns/1ps
`include "stm_cfg.svh"
module stm_top
   import stm_pkg::*;
#(
   parameter int unsigned CONV_CYCLES = `STM_CONV_CYC,
   parameter int unsigned TMO_CYCLES = `STM_TMO_CYC,
   parameter logic [6:0] SADDR_BASE = `STM_SADDR_BASE
)
(
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // smbus pins
   input wire logic serial_clock_line,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe,
   // address straps, tri-level sense codes
   input wire logic [1:0] addr_sel_0,
   input wire logic [1:0] addr_sel_1,
   // converter results, same clock
   input wire logic [3:0][7:0] conv_sample,
   // open-drain alarms
   output logic over_limit_int_o,
   output logic over_limit_int_oe,
   output logic critical_alarm_n_o,
   output logic critical_alarm_n_oe,
   // interrupt
   output logic irq
);

   // pin synchronisers for clock, data and straps
   logic [5:0] pin_s;
   logic scl, sda;
   stm_sync #(.W(6), .RST(6'h3f)) u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d({addr_sel_1, addr_sel_0, serial_data_line_i, serial_clock_line}),
      .q(pin_s)
   );
   assign scl = pin_s[0];
   assign sda = pin_s[1];

   function automatic logic [6:0] tri_idx(input logic [1:0] c);
      if (c == `STM_TRI_LOW)
         return 7'h0;
      else if (c == `STM_TRI_HIGH)
         return 7'h1;
      else
         return 7'h2;
   endfunction : tri_idx

   // straps caught once; the filtered levels only hold the pins from edge four on
   logic [2:0] strap_cnt_q, strap_cnt_d;
   logic [6:0] saddr_q, saddr_d;
   always_comb
   begin
      strap_cnt_d = strap_cnt_q;
      saddr_d = saddr_q;
      if (strap_cnt_q != 3'h5)
      begin
         strap_cnt_d = strap_cnt_q + 3'h1;
         if (strap_cnt_q == 3'h4)
            saddr_d = SADDR_BASE + 7'h3 * tri_idx(pin_s[5:4]) + tri_idx(pin_s[3:2]);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_cnt_q <= 3'h0;
         saddr_q <= 7'h0;
      end
      else
      begin
         strap_cnt_q <= strap_cnt_d;
         saddr_q <= saddr_d;
      end
   end

   // conversion sequencer
   logic [7:0] ctrl_q, ctrl_d;
   stm_conv_if cif();
   // pass ceiling keeps the 600 to 460 ratio of the nominal pass
   stm_conv #(.CONV_CYCLES(CONV_CYCLES), .MAX_CYCLES(CONV_CYCLES / 23 * 30)) u_conv
   (
      .pclk(pclk),
      .presetn(presetn),
      .conv_enable(ctrl_q[0]),
      .sample(conv_sample),
      .cif(cif.conv)
   );

   // limit compare, signed two's complement
   logic [3:0][7:0] high_q, high_d;
   logic [7:0] crit_q, crit_d;
   logic over_high, over_crit;
   always_comb
   begin
      over_high = 1'b0;
      over_crit = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         if ($signed(cif.temp[i]) > $signed(high_q[i]))
            over_high = 1'b1;
         if ($signed(cif.temp[i]) > $signed(crit_q))
            over_crit = 1'b1;
      end
   end

   function automatic logic [7:0] rd_byte(input logic [7:0] p,
                                          input logic [3:0][7:0] t,
                                          input logic [3:0][7:0] h,
                                          input logic [7:0] c);
      if (p < `STM_PTR_HIGH0)
         return t[p[1:0]];
      else if (p < `STM_PTR_CRIT)
         return h[p[1:0]];
      else if (p == `STM_PTR_CRIT)
         return c;
      else
         return 8'h00;
   endfunction : rd_byte

   // smbus slave, sampled on the filtered line levels
   stm_sm_t state_q, state_d;
   logic [3:0] bcnt_q, bcnt_d;
   logic [7:0] shr_q, shr_d, ptr_q, ptr_d;
   logic rw_q, rw_d, mack_q, mack_d, sda_oe_q, sda_oe_d;
   logic scl_p_q, sda_p_q;
   logic [31:0] tmo_q, tmo_d;
   logic scl_rise, scl_fall, start, stop, smb_we, tmo_ev;
   assign scl_rise = scl & ~scl_p_q;
   assign scl_fall = ~scl & scl_p_q;
   assign start = scl & scl_p_q & sda_p_q & ~sda;
   assign stop = scl & scl_p_q & ~sda_p_q & sda;

   always_comb
   begin
      logic [7:0] nb;
      nb = rd_byte(ptr_q + 8'h1, cif.temp, high_q, crit_q);
      state_d = state_q;
      bcnt_d = bcnt_q;
      shr_d = shr_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      mack_d = mack_q;
      sda_oe_d = sda_oe_q;
      smb_we = 1'b0;
      tmo_ev = 1'b0;
      tmo_d = (scl || state_q == S_IDLE) ? 32'h0 : tmo_q + 32'h1;
      // a held-low clock abandons the frame and frees the data line
      if (tmo_q >= 32'(TMO_CYCLES))
      begin
         state_d = S_IDLE;
         sda_oe_d = 1'b0;
         tmo_d = 32'h0;
         tmo_ev = 1'b1;
      end
      else if (start)
      begin
         state_d = S_ADDR;
         bcnt_d = 4'h0;
         sda_oe_d = 1'b0;
      end
      else if (stop)
      begin
         state_d = S_IDLE;
         sda_oe_d = 1'b0;
      end
      else if (scl_rise)
      begin
         case (state_q)
            S_ADDR, S_PTR, S_WDATA:
            begin
               shr_d = {shr_q[6:0], sda};
               bcnt_d = bcnt_q + 4'h1;
            end
            S_RDATA: bcnt_d = bcnt_q + 4'h1;
            S_MACK: mack_d = ~sda;
            default: ;
         endcase
      end
      else if (scl_fall)
      begin
         case (state_q)
            S_ADDR:
               if (bcnt_q == 4'h8)
               begin
                  if (shr_q[7:1] == saddr_q)
                  begin
                     rw_d = shr_q[0];
                     sda_oe_d = 1'b1;
                     state_d = S_ACK_A;
                  end
                  else
                     state_d = S_IDLE;
               end
            S_ACK_A:
            begin
               bcnt_d = 4'h0;
               if (rw_q)
               begin
                  shr_d = rd_byte(ptr_q, cif.temp, high_q, crit_q);
                  sda_oe_d = ~shr_d[7];
                  state_d = S_RDATA;
               end
               else
               begin
                  sda_oe_d = 1'b0;
                  state_d = S_PTR;
               end
            end
            S_PTR:
               if (bcnt_q == 4'h8)
               begin
                  ptr_d = shr_q;
                  sda_oe_d = 1'b1;
                  state_d = S_ACK_P;
               end
            S_ACK_P, S_ACK_W:
            begin
               sda_oe_d = 1'b0;
               bcnt_d = 4'h0;
               if (state_q == S_ACK_W)
                  ptr_d = ptr_q + 8'h1;
               state_d = S_WDATA;
            end
            S_WDATA:
               if (bcnt_q == 4'h8)
               begin
                  smb_we = 1'b1;
                  sda_oe_d = 1'b1;
                  state_d = S_ACK_W;
               end
            S_RDATA:
               if (bcnt_q == 4'h8)
               begin
                  sda_oe_d = 1'b0;
                  state_d = S_MACK;
               end
               else
               begin
                  shr_d = {shr_q[6:0], 1'b0};
                  sda_oe_d = ~shr_q[6];
               end
            S_MACK:
               if (mack_q)
               begin
                  ptr_d = ptr_q + 8'h1;
                  shr_d = nb;
                  sda_oe_d = ~nb[7];
                  bcnt_d = 4'h0;
                  state_d = S_RDATA;
               end
               else
                  state_d = S_IDLE;
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= S_IDLE;
         bcnt_q <= 4'h0;
         shr_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         sda_oe_q <= 1'b0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         tmo_q <= 32'h0;
      end
      else
      begin
         state_q <= state_d;
         bcnt_q <= bcnt_d;
         shr_q <= shr_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         mack_q <= mack_d;
         sda_oe_q <= sda_oe_d;
         scl_p_q <= scl;
         sda_p_q <= sda;
         tmo_q <= tmo_d;
      end
   end

   // register file; one wait state so read data comes from a flop
   logic [3:0] status_q, status_d, enable_q, enable_d, clr;
   logic [31:0] prdata_q, prdata_d, rd;
   logic pready_q, pready_d, pslverr_q, pslverr_d, hit, wr;
   logic int_oe_q, crit_oe_q, irq_q, irq_d;
   always_comb
   begin
      hit = 1'b1;
      rd = 32'h0;
      if (paddr == `STM_OFF_CTRL)
         rd = {24'h0, ctrl_q};
      else if (paddr == `STM_OFF_STATUS)
         rd = {28'h0, status_q};
      else if (paddr == `STM_OFF_CLEAR)
         rd = 32'h0;
      else if (paddr == `STM_OFF_ENABLE)
         rd = {28'h0, enable_q};
      else if (paddr == `STM_OFF_TEMP)
         rd = cif.temp;
      else if (paddr == `STM_OFF_HIGH)
         rd = high_q;
      else if (paddr == `STM_OFF_CRIT)
         rd = {24'h0, crit_q};
      else if (paddr == `STM_OFF_PINS)
         rd = {17'h0, saddr_q, 6'h0, crit_oe_q, int_oe_q};
      else
         hit = 1'b0;
      pready_d = psel & penable & ~pready_q;
      prdata_d = pready_d ? rd : 32'h0;
      pslverr_d = pready_d & ~hit;
      wr = psel & penable & pready_q & pwrite & hit;
      ctrl_d = ctrl_q;
      enable_d = enable_q;
      high_d = high_q;
      crit_d = crit_q;
      clr = 4'h0;
      if (wr && paddr == `STM_OFF_CTRL)
         ctrl_d = pwdata[7:0];
      if (wr && paddr == `STM_OFF_ENABLE)
         enable_d = pwdata[3:0];
      if (wr && paddr == `STM_OFF_CLEAR)
         clr = pwdata[3:0];
      if (wr && paddr == `STM_OFF_HIGH)
         high_d = pwdata;
      if (wr && paddr == `STM_OFF_CRIT)
         crit_d = pwdata[7:0];
      // smbus write lands last, so it wins a same-cycle collision
      if (smb_we && ptr_q >= `STM_PTR_HIGH0 && ptr_q < `STM_PTR_CRIT)
         high_d[ptr_q[1:0]] = shr_q;
      if (smb_we && ptr_q == `STM_PTR_CRIT)
         crit_d = shr_q;
      // set beats clear
      status_d = status_q & ~clr;
      status_d[`STM_EV_HIGH] = status_d[`STM_EV_HIGH] | (over_high & ~int_oe_q);
      status_d[`STM_EV_CRIT] = status_d[`STM_EV_CRIT] | (over_crit & ~crit_oe_q);
      status_d[`STM_EV_DONE] = status_d[`STM_EV_DONE] | cif.done;
      status_d[`STM_EV_TMO] = status_d[`STM_EV_TMO] | tmo_ev;
      irq_d = |(status_q & enable_q);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= {7'h0, `STM_CTRL_RST};
         enable_q <= 4'h0;
         status_q <= 4'h0;
         high_q <= {4{`STM_LIMIT_RST}};
         crit_q <= `STM_LIMIT_RST;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
         int_oe_q <= 1'b0;
         crit_oe_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         enable_q <= enable_d;
         status_q <= status_d;
         high_q <= high_d;
         crit_q <= crit_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q <= irq_d;
         int_oe_q <= over_high;
         crit_oe_q <= over_crit;
      end
   end

   // open-drain pads only ever pull low
   logic low_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_q <= 1'b0;
      else
         low_q <= 1'b0;
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign serial_data_line_o = low_q;
   assign serial_data_line_oe = sda_oe_q;
   assign over_limit_int_o = low_q;
   assign over_limit_int_oe = int_oe_q;
   assign critical_alarm_n_o = low_q;
   assign critical_alarm_n_oe = crit_oe_q;
   assign irq = irq_q;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic post_rst_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         post_rst_q <= 1'b0;
      else
         post_rst_q <= 1'b1;
   end

   sequence s_addr_match;
      state_q == S_ADDR && scl_fall && bcnt_q == 4'h8 && shr_q[7:1] == saddr_q
         && !start && !stop && tmo_q < 32'(TMO_CYCLES);
   endsequence
   sequence s_ack_held;
      sda_oe_q && state_q == S_ACK_A;
   endsequence

   property p_int_follow;
      over_high |=> over_limit_int_oe;
   endproperty
   a_int_follow: assert property (p_int_follow) else $error("int not asserted");
   property p_crit_follow;
      over_crit |=> critical_alarm_n_oe;
   endproperty
   a_crit_follow: assert property (p_crit_follow) else $error("crit not asserted");
   property p_release;
      !over_high && !over_crit |=> !over_limit_int_oe && !critical_alarm_n_oe;
   endproperty
   a_release: assert property (p_release) else $error("alarm not released");
   property p_crit_rb;
      psel && penable && pready && pwrite && paddr == `STM_OFF_CRIT && !smb_we
         |=> crit_q == $past(pwdata[7:0]);
   endproperty
   a_crit_rb: assert property (p_crit_rb) else $error("crit write lost");
   property p_default;
      !post_rst_q |-> crit_q == `STM_LIMIT_RST && high_q == {4{`STM_LIMIT_RST}};
   endproperty
   a_default: assert property (p_default) else $error("bad limit reset");
   property p_addr;
      strap_cnt_q == 3'h5 |-> (saddr_q - SADDR_BASE) <= 7'h8;
   endproperty
   a_addr: assert property (p_addr) else $error("address out of set");
   property p_ack;
      s_addr_match |=> s_ack_held;
   endproperty
   a_ack: assert property (p_ack) else $error("address not acked");
   property p_tmo;
      tmo_q >= 32'(TMO_CYCLES) |=> state_q == S_IDLE && !serial_data_line_oe;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout ignored");
   property p_irq;
      irq == $past(|(status_q & enable_q));
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

endmodule : stm_top

// ===== rtl/stm_cfg.svh
`ifndef STM_CFG_SVH
`define STM_CFG_SVH

// apb register byte offsets
`define STM_OFF_CTRL 8'h00
`define STM_OFF_STATUS 8'h04
`define STM_OFF_CLEAR 8'h08
`define STM_OFF_ENABLE 8'h0c
`define STM_OFF_TEMP 8'h10
`define STM_OFF_HIGH 8'h14
`define STM_OFF_CRIT 8'h18
`define STM_OFF_PINS 8'h1c

// event bit positions in status, clear and enable
`define STM_EV_HIGH 0
`define STM_EV_CRIT 1
`define STM_EV_DONE 2
`define STM_EV_TMO 3

// reset values
`define STM_LIMIT_RST 8'h7f
`define STM_CTRL_RST 1'b1

// smbus register pointers
`define STM_PTR_TEMP0 8'h00
`define STM_PTR_HIGH0 8'h04
`define STM_PTR_CRIT 8'h08

// strap codes from the tri-level sense front end
`define STM_TRI_LOW 2'h0
`define STM_TRI_HIGH 2'h1
`define STM_TRI_OPEN 2'h2
`define STM_SADDR_BASE 7'h18

// timing
`define STM_CLK_KHZ 100000
`define STM_CONV_MS 460
`define STM_CONV_MAX_MS 600
`define STM_TMO_MS 25
`define STM_CONV_CYC (`STM_CONV_MS * `STM_CLK_KHZ)
`define STM_CONV_MAX_CYC (`STM_CONV_MAX_MS * `STM_CLK_KHZ)
`define STM_TMO_CYC (`STM_TMO_MS * `STM_CLK_KHZ)

`endif

// ===== rtl/stm_pkg.sv
package stm_pkg;

   typedef logic [7:0] stm_temp_t;

   typedef enum logic [3:0]
   {
      S_IDLE = 4'h0,
      S_ADDR = 4'h1,
      S_ACK_A = 4'h2,
      S_PTR = 4'h3,
      S_ACK_P = 4'h4,
      S_WDATA = 4'h5,
      S_ACK_W = 4'h6,
      S_RDATA = 4'h7,
      S_MACK = 4'h8
   } stm_sm_t;

endpackage : stm_pkg

// ===== rtl/stm_conv_if.sv
`timescale 1ns/1ps
interface stm_conv_if;
   logic [3:0][7:0] temp;
   logic done;
   modport conv (output temp, output done);
   modport core (input temp, input done);
endinterface : stm_conv_if

// ===== rtl/stm_sync.sv
`timescale 1ns/1ps
module stm_sync
   import stm_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // raw and filtered levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_q, s2_q, s3_q, q_q, q_d;

   // a bit moves only once stages two and three agree
   always_comb
   begin
      q_d = (s2_q & s3_q) | (q_q & (s2_q ^ s3_q));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         q_q <= RST;
      end
      else
      begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q_q <= q_d;
      end
   end

   assign q = q_q;

endmodule : stm_sync

// ===== rtl/stm_conv.sv
`timescale 1ns/1ps
`include "stm_cfg.svh"
module stm_conv
   import stm_pkg::*;
#(
   parameter int unsigned CONV_CYCLES = `STM_CONV_CYC,
   parameter int unsigned MAX_CYCLES = `STM_CONV_MAX_CYC
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control and converter samples
   input wire logic conv_enable,
   input wire logic [3:0][7:0] sample,
   // results toward the core
   stm_conv_if.conv cif
);

   localparam int unsigned STEP = (CONV_CYCLES / 4 > 0) ? CONV_CYCLES / 4 : 1;

   logic [31:0] cnt_q, cnt_d;
   logic [1:0] ch_q, ch_d;
   logic [3:0][7:0] temp_q, temp_d;
   logic done_q, done_d;

   // round robin over local then three remote channels
   always_comb
   begin
      cnt_d = cnt_q;
      ch_d = ch_q;
      temp_d = temp_q;
      done_d = 1'b0;
      if (!conv_enable)
         cnt_d = 32'h0;
      else if (cnt_q >= 32'(STEP - 1))
      begin
         cnt_d = 32'h0;
         temp_d[ch_q] = sample[ch_q];
         ch_d = ch_q + 2'h1;
         done_d = (ch_q == 2'h3);
      end
      else
         cnt_d = cnt_q + 32'h1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 32'h0;
         ch_q <= 2'h0;
         temp_q <= '0;
         done_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         ch_q <= ch_d;
         temp_q <= temp_d;
         done_q <= done_d;
      end
   end

   assign cif.temp = temp_q;
   assign cif.done = done_q;

   // helper: cycles since the last finished pass
   logic [31:0] gap_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gap_q <= 32'h0;
      else if (done_q || !conv_enable)
         gap_q <= 32'h0;
      else
         gap_q <= gap_q + 32'h1;
   end

   property p_pass_time;
      @(posedge pclk) disable iff (!presetn)
      done_q |-> gap_q <= 32'(MAX_CYCLES);
   endproperty
   a_pass_time: assert property (p_pass_time) else $error("pass too slow");

endmodule : stm_conv

// ===== bench/stm_host_model.sv
`timescale 1ns/1ps
// smbus controller model: owns the clock, pulls data low, resolves the wire
module stm_host_model
(
   // clock
   input wire logic pclk,
   // bus lines
   input wire logic dev_oe,
   output logic scl,
   output logic sda
);
   logic low_q = 1'b0;
   // pull-up wins unless either party pulls low
   assign sda = ~(low_q | dev_oe);
   // clock idles high, driven only by this side
   initial scl = 1'b1;
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : wait_cyc
   // 80 ns bit: six cycles low, two high; the device answers five cycles after a fall
   task automatic start();
      wait_cyc(2);
      low_q <= 1'b0;
      wait_cyc(4);
      scl <= 1'b1;
      wait_cyc(2);
      low_q <= 1'b1;
      wait_cyc(2);
      scl <= 1'b0;
   endtask : start
   task automatic stop();
      wait_cyc(2);
      low_q <= 1'b1;
      wait_cyc(4);
      scl <= 1'b1;
      wait_cyc(2);
      low_q <= 1'b0;
      wait_cyc(8);
   endtask : stop
   task automatic bit_io(input logic d, output logic q);
      wait_cyc(2);
      low_q <= ~d;
      wait_cyc(4);
      scl <= 1'b1;
      wait_cyc(2);
      q = sda;
      scl <= 1'b0;
   endtask : bit_io
   // eight bits msb first, then the acknowledge bit
   task automatic byte_io(input logic [7:0] d, input logic a, output logic [8:0] q);
      for (int i = 8; i >= 0; i--)
         bit_io(i > 0 ? d[i-1] : a, q[i]);
   endtask : byte_io
endmodule : stm_host_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`include "stm_cfg.svh"
module tb_top
   import stm_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, scl, sda, sda_o, sda_oe, int_o, int_oe, crit_o, crit_oe, irq;
   logic [1:0] sel0 = 2'h0, sel1 = 2'h0;
   logic [3:0][7:0] samp = '0, hl, s;
   logic [7:0] cl;
   logic [8:0] r;
   logic [32:0] exp_q[$];
   int miscompares = 0, total_checks = 0;

   initial forever #5 pclk = ~pclk;

   stm_top #(.CONV_CYCLES(400), .TMO_CYCLES(200)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_clock_line(scl),
      .serial_data_line_i(sda), .serial_data_line_o(sda_o), .serial_data_line_oe(sda_oe),
      .addr_sel_0(sel0), .addr_sel_1(sel1), .conv_sample(samp), .over_limit_int_o(int_o),
      .over_limit_int_oe(int_oe), .critical_alarm_n_o(crit_o),
      .critical_alarm_n_oe(crit_oe), .irq(irq));
   stm_host_model host (.pclk(pclk), .dev_oe(sda_oe), .scl(scl), .sda(sda));

   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   // one transfer; a read notes {slverr, data} for the monitor
   task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] d);
      if (!w)
         exp_q.push_back(d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d[31:0];
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // two pass-done events, so every channel holds the new samples
   task automatic pass();
      apb(1'b1, `STM_OFF_ENABLE, 33'h4);
      repeat (2)
      begin
         apb(1'b1, `STM_OFF_CLEAR, 33'h4);
         repeat (2) @(posedge pclk);
         while (irq !== 1'b1)
            @(posedge pclk);
      end
      apb(1'b1, `STM_OFF_ENABLE, 33'h0);
   endtask : pass

   task automatic sm(input logic [7:0] b, input logic ack);
      host.byte_io(b, 1'b1, r);
      check(33'(r[0]), 33'(ack));
   endtask : sm

   // read results checked against the oldest note
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite)
         check({pslverr, prdata}, exp_q.pop_front());

   initial
   begin
      void'($urandom(21870));
      // every low/high/open strap pair, each behind its own reset
      for (int i = 0; i < 9; i++)
      begin
         sel0 <= 2'(i % 3);
         sel1 <= 2'(i / 3);
         presetn <= 1'b0;
         repeat (20) @(posedge pclk);
         presetn <= 1'b1;
         repeat (10) @(posedge pclk);
         apb(1'b0, `STM_OFF_PINS, 33'((`STM_SADDR_BASE + i) << 8));
      end
      $display("test straps done");
      apb(1'b0, `STM_OFF_HIGH, 33'h07f7f7f7f);
      apb(1'b0, `STM_OFF_CRIT, 33'h7f);
      apb(1'b0, `STM_OFF_CTRL, 33'h1);
      apb(1'b0, 8'h20, 33'h100000000);
      for (int i = 0; i < 4; i++)
         hl[i] = 8'h10 + 8'($urandom % 96);
      cl = 8'h20 + 8'($urandom % 80);
      apb(1'b1, `STM_OFF_HIGH, 33'(hl));
      apb(1'b1, `STM_OFF_CRIT, 33'(cl));
      apb(1'b0, `STM_OFF_HIGH, 33'(hl));
      apb(1'b0, `STM_OFF_CRIT, 33'(cl));
      $display("test limits done");
      s = 32'($urandom);
      s[1] = hl[1] + 8'h01;
      s[3] = cl + 8'h01;
      samp <= s;
      pass();
      apb(1'b0, `STM_OFF_TEMP, 33'(s));
      check(33'(int_oe), 33'h1);
      check(33'(crit_oe), 33'h1);
      check(33'({sda_o, int_o, crit_o}), 33'h0);
      apb(1'b0, `STM_OFF_STATUS, 33'h7);
      check(33'(irq), 33'h0);
      apb(1'b1, `STM_OFF_ENABLE, 33'h3);
      repeat (2) @(posedge pclk);
      check(33'(irq), 33'h1);
      apb(1'b1, `STM_OFF_CLEAR, 33'h3);
      repeat (2) @(posedge pclk);
      check(33'(irq), 33'h0);
      $display("test alarms done");
      // equal to the limit is not above it
      for (int i = 0; i < 4; i++)
         s[i] = (hl[i] <= cl) ? hl[i] : cl;
      samp <= s;
      pass();
      check(33'(int_oe), 33'h0);
      check(33'(crit_oe), 33'h0);
      $display("test release done");
      host.start();
      sm(8'h42, 1'b1);
      host.stop();
      host.start();
      sm(8'h40, 1'b0);
      sm(8'h08, 1'b0);
      sm(8'h35, 1'b0);
      host.stop();
      apb(1'b0, `STM_OFF_CRIT, 33'h35);
      host.start();
      sm(8'h40, 1'b0);
      sm(8'h01, 1'b0);
      host.start();
      sm(8'h41, 1'b0);
      host.byte_io(8'hff, 1'b1, r);
      check(33'(r[8:1]), 33'(s[1]));
      host.stop();
      $display("test smbus done");
      // stall with the device driving the first data bit low
      apb(1'b1, `STM_OFF_ENABLE, 33'h8);
      apb(1'b1, `STM_OFF_CLEAR, 33'h8);
      host.start();
      sm(8'h40, 1'b0);
      sm(8'h08, 1'b0);
      host.start();
      sm(8'h41, 1'b0);
      repeat (40) @(posedge pclk);
      check(33'(sda_oe), 33'h1);
      repeat (300) @(posedge pclk);
      check(33'(sda_oe), 33'h0);
      check(33'(irq), 33'h1);
      host.stop();
      $display("test timeout done");
      summarize();
   end

   initial
   begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      summarize();
   end
endmodule : tb_top
